// >>> hw/spwc_power_ctrl.v
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "spwc_consts.vh"
module spwc_power_ctrl
#(
   parameter SHORT_CYCLES    = `SPWC_SHORT_MS * `SPWC_CLK_MHZ * 1000,
   parameter LONG_CYCLES     = `SPWC_LONG_MS * `SPWC_CLK_MHZ * 1000,
   parameter DEBOUNCE_CYCLES = `SPWC_DEBOUNCE_US * `SPWC_CLK_MHZ
)
(
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // board inputs from outside this domain
   input  wire        pwrSwitch_n,
   input  wire        rtcAlarm,
   input  wire        lanWake,
   input  wire        usbWake,
   input  wire        pcieWake_n,
   input  wire        infrared_remote_wake,
   input  wire        acReturned,
   input  wire        dualColourLed,
   // register port
   input  wire [3:0]  regAddr,
   input  wire [7:0]  regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [7:0]  regRdata,
   // power and indicators
   output reg         mainPowerOn,
   output reg         resumeFromRam,
   output reg         monitorWake,
   output reg         ledGreen,
   output reg         ledAmber,
   output reg         standbyLed,
   output wire        irq
);

   // ****************************************
   // states
   // ****************************************
   localparam [4:0] ST_OFF   = 5'h01;
   localparam [4:0] ST_WORK  = 5'h02;
   localparam [4:0] ST_S3    = 5'h04;
   localparam [4:0] ST_S4    = 5'h08;
   localparam [4:0] ST_OUTAGE = 5'h10;

   // ****************************************
   // input synchronisers
   // ****************************************
   reg  [7:0] syncA_reg;
   reg  [7:0] syncB_reg;
   wire [7:0] rawIn;
   assign rawIn = {dualColourLed, acReturned, infrared_remote_wake, ~pcieWake_n,
                   usbWake, lanWake, rtcAlarm, ~pwrSwitch_n};

   // two flops on every board input pin before use
   // a source must hold its level over a whole clock, or a short pulse can be lost
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         syncA_reg <= 8'h00;
         syncB_reg <= 8'h00;
      end
      else
      begin
         syncA_reg <= rawIn;
         syncB_reg <= syncA_reg;
      end
   end

   wire swRaw  = syncB_reg[0];
   wire rtcW   = syncB_reg[1];
   wire lanW   = syncB_reg[2];
   wire usbW   = syncB_reg[3];
   wire pcieW  = syncB_reg[4];
   wire irW    = syncB_reg[5];
   wire acRet  = syncB_reg[6];
   wire dualLed = syncB_reg[7];

   // ****************************************
   // registers
   // ****************************************
   reg [`SPWC_CTRL_WIDTH-1:0] ctrl_reg;
   reg [`SPWC_IRQ_WIDTH-1:0]  irqStat_reg;
   reg [`SPWC_IRQ_WIDTH-1:0]  irqStat_next;
   reg [`SPWC_IRQ_WIDTH-1:0]  irqMask_reg;
   reg [4:0]                  state_reg;
   reg [4:0]                  state_next;
   reg [4:0]                  lastState_reg;
   reg                        usbIrArmed_reg;
   reg                        afterG3_reg;
   reg                        acRetPrev_reg;
   reg [1:0]                  lastPress_reg;

   // ****************************************
   // switch debounce and hold timer
   // ****************************************
   reg                        swStable_reg;
   reg [`SPWC_CNT_WIDTH-1:0]  dbCnt_reg;
   reg [`SPWC_CNT_WIDTH-1:0]  holdCnt_reg;
   reg                        longDone_reg;
   wire                       swRelease = swStable_reg & ~swRaw & (dbCnt_reg == DEBOUNCE_CYCLES);
   wire                       shortPress;
   wire                       longPress;

   // stable level only after the raw level held for the debounce time
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         swStable_reg <= 1'b0;
         dbCnt_reg    <= {`SPWC_CNT_WIDTH{1'b0}};
      end
      else if (swRaw == swStable_reg)
         dbCnt_reg <= {`SPWC_CNT_WIDTH{1'b0}};
      else if (dbCnt_reg == DEBOUNCE_CYCLES)
      begin
         swStable_reg <= swRaw;
         dbCnt_reg    <= {`SPWC_CNT_WIDTH{1'b0}};
      end
      else
         dbCnt_reg <= dbCnt_reg + 1'b1;
   end

   // hold counter saturates; long press acts while held, not on release
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         holdCnt_reg  <= {`SPWC_CNT_WIDTH{1'b0}};
         longDone_reg <= 1'b0;
      end
      else if (!swStable_reg)
      begin
         holdCnt_reg  <= {`SPWC_CNT_WIDTH{1'b0}};
         longDone_reg <= 1'b0;
      end
      else
      begin
         if (holdCnt_reg != LONG_CYCLES)
            holdCnt_reg <= holdCnt_reg + 1'b1;
         if (longPress)
            longDone_reg <= 1'b1;
      end
   end

   // presses between four and six seconds do nothing by design
   assign shortPress = swRelease & (holdCnt_reg < SHORT_CYCLES);
   assign longPress  = swStable_reg & ~longDone_reg & (holdCnt_reg == LONG_CYCLES);

   // ****************************************
   // wake qualification
   // ****************************************
   // usb and infrared need the re-arm after mains return; pcie is always live, rtc needs its arm bit, lan is blocked in off after a mains loss in deep sleep
   wire inS3   = state_reg == ST_S3;
   wire inS45  = (state_reg == ST_S4) | (state_reg == ST_OFF);
   wire deep   = ctrl_reg[`SPWC_CTRL_DEEP_SLEEP];
   wire usbOk  = usbW & usbIrArmed_reg & (inS3 | (~deep & ctrl_reg[`SPWC_CTRL_USB_S45]));
   wire irOk   = irW & usbIrArmed_reg & (inS3 | ~deep);
   wire lanOk  = lanW & ~(afterG3_reg & (state_reg == ST_OFF) & deep);
   wire rtcOk  = rtcW & ctrl_reg[`SPWC_CTRL_RTC_ARMED];
   wire quiet  = rtcOk | lanOk | pcieW;
   wire wakeEv = (inS3 | inS45) & (shortPress | quiet | usbOk | irOk);
   // a fall of the synced supply flag means mains went away without a reset
   wire acRise = acRet & ~acRetPrev_reg;
   wire acFall = ~acRet & acRetPrev_reg;

   // ****************************************
   // state machine
   // ****************************************
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         // the policy picks the state to come back to once mains return
         ST_OUTAGE:
            if (acRise)
            begin
               case (ctrl_reg[`SPWC_CTRL_RESTORE_HI:`SPWC_CTRL_RESTORE_LO])
                  `SPWC_RESTORE_ON:   state_next = ST_WORK;
                  `SPWC_RESTORE_LAST: state_next = (lastState_reg == ST_WORK) ? ST_WORK : ST_OFF;
                  default:            state_next = ST_OFF;
               endcase
            end
         ST_WORK:
            if (longPress)
               state_next = ST_OFF;
            else if (shortPress & ctrl_reg[`SPWC_CTRL_OS_SLEEP])
               state_next = ctrl_reg[`SPWC_CTRL_SLEEP_S4] ? ST_S4 : ST_S3;
         ST_S3, ST_S4:
            if (longPress)
               state_next = ST_OFF;
            else if (wakeEv)
               state_next = ST_WORK;
         ST_OFF:
            if (wakeEv)
               state_next = ST_WORK;
         default:
            state_next = ST_OFF;
      endcase
      // losing mains pulls every state back to the outage wait; sleep
      // context and a running press mean nothing once main power is gone
      if (acFall)
         state_next = ST_OUTAGE;
   end

   // state, wake side effects and outputs
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_reg     <= ST_OUTAGE;
         lastState_reg <= ST_OFF;
         acRetPrev_reg <= 1'b0;
         afterG3_reg   <= 1'b1;
         resumeFromRam <= 1'b0;
         monitorWake   <= 1'b0;
         mainPowerOn   <= 1'b0;
         ledGreen      <= 1'b0;
         ledAmber      <= 1'b0;
         standbyLed    <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         acRetPrev_reg <= acRet;
         // sleep counts as off for the restore policy; the outage wait keeps the old value
         if (state_next != ST_OUTAGE)
            lastState_reg <= (state_next == ST_WORK) ? ST_WORK : ST_OFF;
         // a mains loss starts a new mechanical-off interval for the lan restriction
         if (acFall)
            afterG3_reg <= 1'b1;
         else if (state_reg == ST_WORK)
            afterG3_reg <= 1'b0;
         if (wakeEv && state_next == ST_WORK)
         begin
            resumeFromRam <= inS3;
            monitorWake   <= ~(quiet & ~shortPress & ~usbOk & ~irOk);
         end
         else if (state_reg == ST_OUTAGE || (state_reg == ST_OFF && state_next == ST_WORK))
         begin
            resumeFromRam <= 1'b0;
            monitorWake   <= 1'b1;
         end
         // main supply follows the working state only; sleep and off both keep it down
         mainPowerOn <= (state_next == ST_WORK);
         ledGreen    <= (state_next == ST_WORK);
         ledAmber    <= (state_next == ST_S3) & dualLed;
         standbyLed  <= 1'b1;
      end
   end

   // ****************************************
   // register port and interrupts
   // ****************************************
   // one decode of the write strobe, shared by every writable register
   function wrHit;
      input [3:0] addr;
      input [3:0] want;
      input       strobe;
      begin
         wrHit = strobe & (addr == want);
      end
   endfunction

   wire [`SPWC_IRQ_WIDTH-1:0] events;
   // sleep entry only; a forced power-off or a mains loss is not a sleep
   assign events = {(state_reg == ST_WORK) & ((state_next == ST_S3) | (state_next == ST_S4)),
                    longPress, shortPress, wakeEv};

   // set wins over a write-one clear in the same cycle
   always @*
   begin
      irqStat_next = irqStat_reg;
      if (wrHit(regAddr, `SPWC_ADDR_IRQ_STAT, regWr))
         irqStat_next = irqStat_reg & ~regWdata[`SPWC_IRQ_WIDTH-1:0];
      irqStat_next = irqStat_next | events;
   end

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ctrl_reg       <= `SPWC_CTRL_RESET;
         irqStat_reg    <= {`SPWC_IRQ_WIDTH{1'b0}};
         irqMask_reg    <= {`SPWC_IRQ_WIDTH{1'b0}};
         usbIrArmed_reg <= 1'b0;
         lastPress_reg  <= 2'h0;
         regRdata       <= 8'h00;
      end
      else
      begin
         irqStat_reg <= irqStat_next;
         if (shortPress | longPress)
            lastPress_reg <= {longPress, shortPress};
         // AC return disarms; a write of the re-arm bit arms again
         if (acRise)
            usbIrArmed_reg <= 1'b0;
         else if (wrHit(regAddr, `SPWC_ADDR_CTRL, regWr) && regWdata[`SPWC_CTRL_REARM])
            usbIrArmed_reg <= 1'b1;
         if (wrHit(regAddr, `SPWC_ADDR_CTRL, regWr))
            ctrl_reg <= regWdata;
         if (wrHit(regAddr, `SPWC_ADDR_IRQ_MASK, regWr))
            irqMask_reg <= regWdata[`SPWC_IRQ_WIDTH-1:0];
         // zero outside the one-cycle slot, so stale data never looks valid
         regRdata <= 8'h00;
         if (regRd)
         begin
            case (regAddr)
               `SPWC_ADDR_CTRL:     regRdata <= ctrl_reg;
               `SPWC_ADDR_STATE:    regRdata <= {2'h0, usbIrArmed_reg, state_reg};
               `SPWC_ADDR_IRQ_STAT: regRdata <= {4'h0, irqStat_reg};
               `SPWC_ADDR_IRQ_MASK: regRdata <= {4'h0, irqMask_reg};
               `SPWC_ADDR_PRESS:    regRdata <= {6'h00, lastPress_reg};
               default:             regRdata <= 8'h00;
            endcase
         end
      end
   end

   assign irq = |(irqStat_reg & irqMask_reg);

endmodule
`default_nettype wire

// >>> common/spwc_consts.vh
`ifndef SPWC_CONSTS_VH
`define SPWC_CONSTS_VH
// ****************************************
// address map (word addresses on the plain port)
// ****************************************
`define SPWC_ADDR_CTRL     4'h0
`define SPWC_ADDR_STATE    4'h1
`define SPWC_ADDR_IRQ_STAT 4'h2
`define SPWC_ADDR_IRQ_MASK 4'h3
`define SPWC_ADDR_PRESS    4'h4
// ****************************************
// control register fields
// ****************************************
`define SPWC_CTRL_OS_SLEEP   0
`define SPWC_CTRL_DEEP_SLEEP 1
`define SPWC_CTRL_USB_S45    2
`define SPWC_CTRL_RESTORE_LO 3
`define SPWC_CTRL_RESTORE_HI 4
`define SPWC_CTRL_REARM      5
`define SPWC_CTRL_SLEEP_S4   6
`define SPWC_CTRL_RTC_ARMED  7
`define SPWC_CTRL_WIDTH      8
`define SPWC_CTRL_RESET      8'h00
// ****************************************
// restore-after-outage policy codes
// ****************************************
`define SPWC_RESTORE_OFF  2'h0
`define SPWC_RESTORE_ON   2'h1
`define SPWC_RESTORE_LAST 2'h2
// ****************************************
// interrupt status fields
// ****************************************
`define SPWC_IRQ_WAKE   0
`define SPWC_IRQ_SHORT  1
`define SPWC_IRQ_LONG   2
`define SPWC_IRQ_SLEEP  3
`define SPWC_IRQ_WIDTH  4
// ****************************************
// timing
// ****************************************
`define SPWC_CLK_MHZ      250
`define SPWC_SHORT_MS     4000
`define SPWC_LONG_MS      6000
`define SPWC_DEBOUNCE_US  10
`define SPWC_CNT_WIDTH    32
`endif

// >>> sim/spwc_power_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks of the power controller
// ****
module spwc_power_ctrl_monitor
#(
   parameter LONG_CYCLES     = 60,
   parameter DEBOUNCE_CYCLES = 3
)
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // board inputs
   input wire logic       pwrSwitch_n,
   input wire logic       lanWake,
   input wire logic       pcieWake_n,
   input wire logic       dualColourLed,
   // register port
   input wire logic       regRd,
   input wire logic [7:0] regRdata,
   // power and indicators
   input wire logic       mainPowerOn,
   input wire logic       resumeFromRam,
   input wire logic       ledAmber,
   input wire logic       standbyLed
);
   // margin covers sync flops, debounce and output register
   localparam int HOLD_LIM = LONG_CYCLES + DEBOUNCE_CYCLES + 12;
   logic [31:0] holdCnt_reg;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // length of the current press, saturating so it never wraps
   always @(posedge ref_clk)
   begin
      if (!rst_n || pwrSwitch_n)
         holdCnt_reg <= 32'h0;
      else if (holdCnt_reg <= HOLD_LIM)
         holdCnt_reg <= holdCnt_reg + 32'h1;
   end
   chk_standby_lit: assert property ($past(rst_n) |-> standbyLed)
      else $error("standby led dark");
   chk_amber_sleep: assert property (ledAmber |-> dualColourLed && !mainPowerOn)
      else $error("amber lit while powered or single led");
   chk_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
      else $error("read data outside its slot");
   chk_long_off: assert property (holdCnt_reg > HOLD_LIM |-> !mainPowerOn && !ledAmber)
      else $error("long press did not force soft off");
   chk_resume_ram: assert property ($rose(mainPowerOn) && $past(ledAmber) |-> resumeFromRam)
      else $error("suspend wake not a resume");
   chk_cold_boot: assert property ($rose(mainPowerOn) && dualColourLed && !$past(ledAmber)
      |-> !resumeFromRam)
      else $error("resume flagged on cold boot");
   chk_pcie_wake: assert property (ledAmber && $fell(pcieWake_n) |-> ##[1:6] mainPowerOn)
      else $error("pcie wake ignored in suspend");
   chk_lan_wake: assert property (ledAmber && $rose(lanWake) |-> ##[1:6] mainPowerOn)
      else $error("lan wake ignored in suspend");
endmodule
bind spwc_power_ctrl spwc_power_ctrl_monitor #(.LONG_CYCLES(LONG_CYCLES),
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
   .pwrSwitch_n(pwrSwitch_n), .lanWake(lanWake), .pcieWake_n(pcieWake_n),
   .dualColourLed(dualColourLed), .regRd(regRd), .regRdata(regRdata),
   .mainPowerOn(mainPowerOn), .resumeFromRam(resumeFromRam), .ledAmber(ledAmber),
   .standbyLed(standbyLed));
`default_nettype wire

// >>> sim/spwc_board_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// switch, wake sources and supply
// ****
module spwc_board_model
(
   // clock
   input wire logic ref_clk,
   // lines toward the controller
   output var logic pwrSwitch_n,
   output var logic rtcAlarm,
   output var logic lanWake,
   output var logic usbWake,
   output var logic pcieWake_n,
   output var logic infrared_remote_wake,
   output var logic acReturned
);
   // idle: switch open, no wake, no supply
   initial
   begin
      {pwrSwitch_n, pcieWake_n} = 2'h3;
      {rtcAlarm, lanWake, usbWake, infrared_remote_wake, acReturned} = 5'h00;
   end
   // contact bounce shorter than the debounce window comes first
   task automatic press(input int n);
      @(posedge ref_clk) pwrSwitch_n <= 1'b0;
      @(posedge ref_clk) pwrSwitch_n <= 1'b1;
      @(posedge ref_clk) pwrSwitch_n <= 1'b0;
      repeat (n) @(posedge ref_clk);
      pwrSwitch_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
   // a source holds its request level a while, then lets go
   task automatic wake(input int s);
      @(posedge ref_clk);
      case (s)
         0: lanWake <= 1'b1;
         1: rtcAlarm <= 1'b1;
         2: pcieWake_n <= 1'b0;
         3: usbWake <= 1'b1;
         default: infrared_remote_wake <= 1'b1;
      endcase
      repeat (8) @(posedge ref_clk);
      {rtcAlarm, lanWake, usbWake, infrared_remote_wake} <= 4'h0;
      pcieWake_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic setAc(input logic v);
      @(posedge ref_clk) acReturned <= v;
      repeat (6) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// >>> sim/spwc_power_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "spwc_consts.vh"
module spwc_power_ctrl_test;
   localparam logic [4:0] OFF = 5'h01, WORK = 5'h02, S3 = 5'h04, S4 = 5'h08;
   logic       ref_clk, rst_n, regWr, regRd;
   logic [3:0] regAddr;
   logic [7:0] regWdata;
   logic       dualLed;
   wire logic  pwrSw_n, rtc, lan, usb, pcie_n, ir, ac;
   wire logic  mainPowerOn, resumeFromRam, monitorWake, ledGreen, ledAmber, standbyLed, irq;
   wire logic [7:0] regRdata;
   // every one-bit output in one vector, so a check can read it after the edge
   wire logic [7:0] outs;
   assign outs = {1'b0, irq, standbyLed, ledAmber, ledGreen, monitorWake, resumeFromRam,
                  mainPowerOn};
   localparam int PWR = 0, RES = 1, MON = 2, GRN = 3, AMB = 4, SBY = 5, IRQ = 6;
   int         fails, checks;
   spwc_board_model u_spwc_board_model (.ref_clk(ref_clk), .pwrSwitch_n(pwrSw_n),
      .rtcAlarm(rtc), .lanWake(lan), .usbWake(usb), .pcieWake_n(pcie_n),
      .infrared_remote_wake(ir), .acReturned(ac));
   spwc_power_ctrl #(.SHORT_CYCLES(40), .LONG_CYCLES(60), .DEBOUNCE_CYCLES(3)) u_spwc_power_ctrl
      (.ref_clk(ref_clk), .rst_n(rst_n), .pwrSwitch_n(pwrSw_n), .rtcAlarm(rtc), .lanWake(lan),
      .usbWake(usb), .pcieWake_n(pcie_n), .infrared_remote_wake(ir), .acReturned(ac),
      .dualColourLed(dualLed), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .mainPowerOn(mainPowerOn),
      .resumeFromRam(resumeFromRam), .monitorWake(monitorWake), .ledGreen(ledGreen),
      .ledAmber(ledAmber), .standbyLed(standbyLed), .irq(irq));
   // ****
   // shared tasks
   // ****
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // polls the state; a refused request simply runs the count out
   task automatic waitSt(input logic [4:0] exp);
      logic [7:0] d;
      int n;
      n = 0;
      do
      begin
         rd(`SPWC_ADDR_STATE, d);
         n++;
      end
      while (d[4:0] !== exp && n < 16);
      cmp("state", {3'h0, exp}, {3'h0, d[4:0]});
   endtask
   task automatic pressTo(input int n, input logic [4:0] st);
      u_spwc_board_model.press(n);
      waitSt(st);
   endtask
   task automatic wakeTo(input int s, input logic [4:0] st);
      u_spwc_board_model.wake(s);
      waitSt(st);
   endtask
   // the output is picked after the edge, not when the task is called
   task automatic flag(input string what, input logic exp, input int idx);
      @(posedge ref_clk);
      #1 cmp(what, {7'h0, exp}, {7'h0, outs[idx]});
   endtask
   // supply lost, controller reset, policy set, supply back
   task automatic outage(input logic [7:0] ctrl);
      u_spwc_board_model.setAc(1'b0);
      @(posedge ref_clk) rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      flag("standby led", 1'b1, SBY);
      waitSt(5'h10);
      wr(`SPWC_ADDR_CTRL, ctrl);
      u_spwc_board_model.setAc(1'b1);
   endtask
   // ****
   // scenarios
   // ****
   task automatic tOutageOff();
      outage(8'h02);
      waitSt(OFF);
      wakeTo(0, OFF);
      wr(`SPWC_ADDR_CTRL, 8'h00);
      wakeTo(0, WORK);
      flag("monitor", 1'b0, MON);
   endtask
   // mains lost and back without a reset: the last state comes back
   task automatic tOutageOn();
      outage(8'h08);
      waitSt(WORK);
      flag("green", 1'b1, GRN);
      wr(`SPWC_ADDR_CTRL, 8'h10);
      u_spwc_board_model.setAc(1'b0);
      waitSt(5'h10);
      flag("supply", 1'b0, PWR);
      u_spwc_board_model.setAc(1'b1);
      waitSt(WORK);
      pressTo(90, OFF);
      u_spwc_board_model.setAc(1'b0);
      u_spwc_board_model.setAc(1'b1);
      waitSt(OFF);
      pressTo(20, WORK);
   endtask
   task automatic tPress();
      logic [7:0] d;
      pressTo(50, WORK);
      pressTo(20, WORK);
      wr(`SPWC_ADDR_CTRL, 8'h01);
      pressTo(20, S3);
      flag("amber", 1'b1, AMB);
      flag("supply", 1'b0, PWR);
      rd(`SPWC_ADDR_PRESS, d);
      cmp("press kind", 8'h01, d);
      pressTo(20, WORK);
      flag("resume", 1'b1, RES);
      pressTo(20, S3);
      pressTo(90, OFF);
      rd(`SPWC_ADDR_PRESS, d);
      cmp("press kind", 8'h02, d);
      pressTo(20, WORK);
      flag("resume", 1'b0, RES);
      pressTo(90, OFF);
   endtask
   // single-colour panel led stays dark in suspend
   task automatic tSingleLed();
      @(posedge ref_clk) dualLed <= 1'b0;
      pressTo(20, WORK);
      flag("green", 1'b1, GRN);
      pressTo(20, S3);
      flag("amber single", 1'b0, AMB);
      flag("green", 1'b0, GRN);
      flag("supply", 1'b0, PWR);
      pressTo(20, WORK);
      flag("resume", 1'b1, RES);
      pressTo(90, OFF);
      @(posedge ref_clk) dualLed <= 1'b1;
   endtask
   // alarm armed so every silent source is tried from suspend
   task automatic tWakeS3();
      pressTo(20, WORK);
      wr(`SPWC_ADDR_CTRL, 8'h81);
      for (int s = 0; s < 3; s++)
      begin
         pressTo(20, S3);
         wakeTo(s, WORK);
         flag("monitor", 1'b0, MON);
      end
   endtask
   task automatic tUsbIr();
      pressTo(20, S3);
      wakeTo(3, S3);
      wakeTo(4, S3);
      wr(`SPWC_ADDR_CTRL, 8'hA1);
      wakeTo(3, WORK);
      wr(`SPWC_ADDR_CTRL, 8'h61);
      pressTo(20, S4);
      wakeTo(3, S4);
      wakeTo(4, WORK);
      wr(`SPWC_ADDR_CTRL, 8'h65);
      pressTo(20, S4);
      wakeTo(3, WORK);
      wr(`SPWC_ADDR_CTRL, 8'h67);
      pressTo(20, S4);
      wakeTo(4, S4);
      wakeTo(2, WORK);
   endtask
   task automatic tRtcIrq();
      logic [7:0] d;
      wr(`SPWC_ADDR_CTRL, 8'h80);
      pressTo(90, OFF);
      wakeTo(1, WORK);
      flag("monitor", 1'b0, MON);
      wr(`SPWC_ADDR_IRQ_STAT, 8'h0F);
      wr(`SPWC_ADDR_IRQ_MASK, 8'h00);
      pressTo(90, OFF);
      flag("irq masked", 1'b0, IRQ);
      wr(`SPWC_ADDR_IRQ_MASK, 8'h04);
      flag("irq", 1'b1, IRQ);
      rd(`SPWC_ADDR_IRQ_STAT, d);
      cmp("status", 8'h04, d);
      wr(`SPWC_ADDR_IRQ_STAT, 8'h04);
      flag("irq cleared", 1'b0, IRQ);
      wr(4'h9, 8'hFF);
      rd(4'h9, d);
      cmp("unmapped", 8'h00, d);
   endtask
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // 4 ns clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // hang guard, more than ten times the expected run
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      stop_test();
   end
   initial
   begin
      {rst_n, regWr, regRd, regAddr, regWdata} = 15'h0;
      {fails, checks} = 64'h0;
      dualLed = 1'b1;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      tOutageOff();
      tOutageOn();
      tPress();
      tSingleLed();
      tWakeS3();
      tUsbIr();
      tRtcIrq();
      stop_test();
   end
endmodule
`default_nettype wire
